// ===== inc/sbxo_pkg.sv
/*
 * Shared constants and types for the synthesizer bias, crystal and output
 * control register bank.
 * Assumes an AHB-Lite master that issues single whole-word transfers.
 */
`default_nettype none

package sbxo_pkg;

    // Register byte offsets within the bank.
    localparam logic [7:0] SBXO_ADDR_BIAS = 8'h00;
    localparam logic [7:0] SBXO_ADDR_XO = 8'h04;
    localparam logic [7:0] SBXO_ADDR_OD = 8'h08;
    localparam logic [7:0] SBXO_ADDR_ODRV = 8'h0C;
    localparam logic [7:0] SBXO_ADDR_IRQ_STS = 8'h10;
    localparam logic [7:0] SBXO_ADDR_IRQ_CLR = 8'h14;
    localparam logic [7:0] SBXO_ADDR_IRQ_EN = 8'h18;

    // Crystal oscillator configuration layout.
    localparam logic [31:0] SBXO_XO_RW_MASK = 32'h0007_FFFF;
    localparam logic [31:0] SBXO_XO_RST = 32'h0001_5F1F;
    localparam int SBXO_XO_LDO_BIT = 16;
    localparam int SBXO_XO_GAIN_LSB = 14;
    localparam int SBXO_XO_CXOUT_LSB = 8;
    localparam int SBXO_XO_CXIN_LSB = 0;
    localparam logic [5:0] SBXO_CAP_MAX = 6'h2F;

    // Output divider configuration layout.
    localparam logic [15:0] SBXO_OD_RW_MASK = 16'hBFFF;
    localparam logic [15:0] SBXO_OD_RST = 16'h8069;
    localparam int SBXO_OD_LDO_BIT = 15;
    localparam logic [13:0] SBXO_OD_MIN = 14'h000A;

    // Output driver enable layout.
    localparam int SBXO_ODRV_PD_BIT = 0;
    localparam int SBXO_ODRV_DIS_BIT = 1;
    localparam int SBXO_ODRV_STATE_LSB = 2;
    localparam logic [3:0] SBXO_ODRV_RST = 4'h0;

    // Interrupt event bit positions.
    localparam int SBXO_IRQ_W = 4;
    localparam int SBXO_EV_CAL_DONE = 0;
    localparam int SBXO_EV_CAL_FAIL = 1;
    localparam int SBXO_EV_CAP_RSVD = 2;
    localparam int SBXO_EV_DIV_LOW = 3;

    typedef enum logic [1:0] {
        SBXO_DIS_LOW = 2'b00,
        SBXO_DIS_SPLIT = 2'b01,
        SBXO_DIS_HIZ = 2'b10,
        SBXO_DIS_RUN = 2'b11
    } sbxo_dis_state_e;

    typedef struct packed {
        logic true_o;
        logic true_oe;
        logic comp_o;
        logic comp_oe;
    } sbxo_pins_s;

    // Calibration inputs from the bias circuit.
    typedef struct packed {
        logic done;
        logic fail;
        logic [2:0] code;
        logic [2:0] eff;
        logic cmp;
    } sbxo_cal_s;

endpackage

`default_nettype wire

// ===== hw/sbxo_pin_mux.sv
/*
 * Output pair steering for the clock output driver.
 * Assumes the caller registers the result before it reaches the pins.
 */
`timescale 1ns/10ps
`default_nettype none

module sbxo_pin_mux
    import sbxo_pkg::*;
(
    // Driver control
    input wire logic power_down,
    input wire logic disabled,
    input wire logic [1:0] dis_state,
    input wire logic lvds_mode,
    // Clock to forward
    input wire logic clk_src,
    // Next pin values
    output sbxo_pins_s pins
);

    sbxo_dis_state_e st;

    always_comb
    begin
        st = sbxo_dis_state_e'(dis_state);
        pins = '{true_o: clk_src, true_oe: 1'b1,
                 comp_o: ~clk_src, comp_oe: 1'b1};
        if (power_down)
        begin
            pins = '0;
        end
        else if (disabled)
        begin
            case (st)
                SBXO_DIS_LOW:
                begin
                    pins.true_o = 1'b0;
                    pins.comp_o = lvds_mode;
                end
                SBXO_DIS_SPLIT:
                begin
                    pins.true_o = 1'b0;
                    pins.comp_o = 1'b1;
                end
                SBXO_DIS_HIZ:
                begin
                    pins = '0;
                end
                SBXO_DIS_RUN:
                begin
                    pins.true_o = clk_src;
                end
                default:
                begin
                    pins = '0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ===== hw/sbxo_regs.sv
/*
 * Register bank for bias calibration status, crystal oscillator settings,
 * output divider and output driver control, reached over AHB-Lite.
 * Assumes single whole-word transfers, calibration inputs and the clock
 * source synchronous to hclk, and a single slave on the bus.
 */
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module sbxo_regs
    import sbxo_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Bias calibration status inputs
    input wire logic cal_done_in,
    input wire logic cal_fail_in,
    input wire logic [2:0] cal_code_in,
    input wire logic [2:0] cal_eff_in,
    input wire logic cal_cmp_in,
    // Output driver inputs
    input wire logic clk_src,
    input wire logic ext_disable,
    input wire logic lvds_mode,
    // Analog controls
    output logic osc_regulator_on,
    output logic [1:0] gain_boost,
    output logic [5:0] cap_xout,
    output logic [5:0] cap_xin,
    output logic divider_regulator_on,
    output logic [13:0] div_ratio,
    // Output pair
    output logic clk_out_true_o,
    output logic clk_out_true_oe,
    output logic clk_out_comp_o,
    output logic clk_out_comp_oe,
    // Interrupt
    output logic irq
);

    typedef struct packed {
        logic [31:0] xo;
        logic [15:0] od;
        logic [3:0] odrv;
        logic [8:0] bias;
        logic [SBXO_IRQ_W-1:0] irq_sts;
        logic [SBXO_IRQ_W-1:0] irq_en;
        logic irq;
        logic ph_act;
        logic ph_wr;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
        logic hrdy;
        sbxo_pins_s pins;
    } sbxo_state_s;

    localparam sbxo_state_s ST_RST = '{
        xo: SBXO_XO_RST,
        od: SBXO_OD_RST,
        odrv: SBXO_ODRV_RST,
        hrdy: 1'b1,
        default: '0
    };

    sbxo_state_s st_reg;
    sbxo_state_s st_next;
    sbxo_pins_s pins_next;
    sbxo_cal_s cal;

    assign cal = '{done: cal_done_in, fail: cal_fail_in, code: cal_code_in,
                   eff: cal_eff_in, cmp: cal_cmp_in};

    sbxo_pin_mux u_pin_mux (
        .power_down(st_reg.odrv[SBXO_ODRV_PD_BIT]),
        .disabled(st_reg.odrv[SBXO_ODRV_DIS_BIT] | ext_disable),
        .dis_state(st_reg.odrv[SBXO_ODRV_STATE_LSB +: 2]),
        .lvds_mode(lvds_mode),
        .clk_src(clk_src),
        .pins(pins_next)
    );

    always_comb
    begin
        logic [SBXO_IRQ_W-1:0] ev;
        logic [SBXO_IRQ_W-1:0] clr;
        logic [31:0] rd;
        logic wr_now;
        ev = '0;
        clr = '0;
        rd = '0;
        st_next = st_reg;
        wr_now = st_reg.ph_act & st_reg.ph_wr;

        // Status fields other than the raw comparator bit 8 are forced to zero
        // until calibration finishes so software never sees a half-settled code.
        // finished bit
        st_next.bias[0] = cal.done;
        st_next.bias[1] = cal.done & cal.fail;
        st_next.bias[4:2] = cal.done ? cal.code : 3'h0;
        st_next.bias[7:5] = cal.done ? cal.eff : 3'h0;
        st_next.bias[8] = cal.cmp;
        ev[SBXO_EV_CAL_DONE] = cal.done & ~st_reg.bias[0];
        ev[SBXO_EV_CAL_FAIL] = cal.done & ~st_reg.bias[0] & cal.fail;

        if (wr_now)
        begin
            case (st_reg.ph_addr)
                SBXO_ADDR_XO:
                begin
                    // regulator bit and masked reserved bits
                    st_next.xo = hwdata & SBXO_XO_RW_MASK;
                    ev[SBXO_EV_CAP_RSVD] =
                        (hwdata[SBXO_XO_CXOUT_LSB +: 6] > SBXO_CAP_MAX) |
                        (hwdata[SBXO_XO_CXIN_LSB +: 6] > SBXO_CAP_MAX);
                end
                SBXO_ADDR_OD:
                begin
                    st_next.od = hwdata[15:0] & SBXO_OD_RW_MASK;
                    ev[SBXO_EV_DIV_LOW] = hwdata[13:0] < SBXO_OD_MIN;
                end
                SBXO_ADDR_ODRV:
                begin
                    st_next.odrv = hwdata[3:0];
                end
                SBXO_ADDR_IRQ_CLR:
                begin
                    clr = hwdata[SBXO_IRQ_W-1:0];
                end
                SBXO_ADDR_IRQ_EN:
                begin
                    st_next.irq_en = hwdata[SBXO_IRQ_W-1:0];
                end
                default:
                begin
                    st_next.irq_en = st_reg.irq_en;
                end
            endcase
        end

        // A new event beats a clear arriving in the same cycle.
        st_next.irq_sts = (st_reg.irq_sts & ~clr) | ev;
        st_next.irq = |(st_next.irq_sts & st_next.irq_en);

        // Address phase of the next transfer.
        st_next.ph_act = hsel & htrans[1] & hready;
        st_next.ph_wr = hwrite;
        st_next.ph_addr = haddr[7:0];

        // Read data is formed from the updated state so a read right after
        // a write sees the new value with no wait state.
        case (haddr[7:0])
            SBXO_ADDR_BIAS: rd = {23'h00_0000, st_next.bias};
            SBXO_ADDR_XO: rd = st_next.xo;
            SBXO_ADDR_OD: rd = {16'h0000, st_next.od};
            SBXO_ADDR_ODRV: rd = {28'h000_0000, st_next.odrv};
            SBXO_ADDR_IRQ_STS: rd = {28'h000_0000, st_next.irq_sts};
            SBXO_ADDR_IRQ_EN: rd = {28'h000_0000, st_next.irq_en};
            default: rd = 32'h0000_0000;
        endcase
        st_next.rdata = (st_next.ph_act & ~hwrite) ? rd : 32'h0000_0000;
        st_next.hrdy = 1'b1;
        st_next.pins = pins_next;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_reg <= ST_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign hreadyout = st_reg.hrdy;
    assign hresp = 1'b0;
    assign hrdata = st_reg.rdata;
    assign osc_regulator_on = st_reg.xo[SBXO_XO_LDO_BIT];
    assign gain_boost = st_reg.xo[SBXO_XO_GAIN_LSB +: 2];
    assign cap_xout = st_reg.xo[SBXO_XO_CXOUT_LSB +: 6];
    assign cap_xin = st_reg.xo[SBXO_XO_CXIN_LSB +: 6];
    assign divider_regulator_on = st_reg.od[SBXO_OD_LDO_BIT];
    assign div_ratio = st_reg.od[13:0];
    assign clk_out_true_o = st_reg.pins.true_o;
    assign clk_out_true_oe = st_reg.pins.true_oe;
    assign clk_out_comp_o = st_reg.pins.comp_o;
    assign clk_out_comp_oe = st_reg.pins.comp_oe;
    assign irq = st_reg.irq;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic wr_xo;
    logic wr_od;
    logic rd_bias;
    logic drv_off;
    assign wr_xo = st_reg.ph_act & st_reg.ph_wr &
                   (st_reg.ph_addr == SBXO_ADDR_XO);
    assign wr_od = st_reg.ph_act & st_reg.ph_wr &
                   (st_reg.ph_addr == SBXO_ADDR_OD);
    assign rd_bias = hsel & htrans[1] & hready & ~hwrite &
                     (haddr[7:0] == SBXO_ADDR_BIAS);
    assign drv_off = ~st_reg.odrv[SBXO_ODRV_PD_BIT] &
                     (st_reg.odrv[SBXO_ODRV_DIS_BIT] | ext_disable);

    a_done_read: assert property (
        rd_bias |=> hrdata[0] == $past(cal_done_in))
        else $error("finished bit read back wrong");
    a_fail_gated: assert property (
        !cal_done_in ##1 1'b1 |-> !st_reg.bias[1])
        else $error("failure bit set before calibration finished");
    a_code_gated: assert property (
        $past(cal_done_in) |-> st_reg.bias[4:2] == $past(cal_code_in))
        else $error("chosen code not reported");
    a_eff_gated: assert property (
        !st_reg.bias[0] |-> st_reg.bias[7:5] == 3'h0)
        else $error("delivered code shown while calibrating");
    a_raw_cmp: assert property (
        rd_bias |=> hrdata[8] == $past(cal_cmp_in, 1))
        else $error("raw comparator not on bit 8");
    a_osc_reg_on: assert property (
        wr_xo |=> osc_regulator_on == $past(hwdata[16]))
        else $error("oscillator regulator not following write");
    a_gain_field: assert property (
        wr_xo |=> gain_boost == $past(hwdata[15:14]))
        else $error("gain boost field wrong");
    a_div_reg_on: assert property (
        wr_od |=> divider_regulator_on == $past(hwdata[15]) &&
        div_ratio == $past(hwdata[13:0]))
        else $error("divider register not following write");
    a_pd_tristate: assert property (
        st_reg.odrv[SBXO_ODRV_PD_BIT] |=> !clk_out_true_oe &&
        !clk_out_comp_oe)
        else $error("pins driven while powered down");
    a_dis_split: assert property (
        drv_off && st_reg.odrv[3:2] == 2'b01 |=>
        clk_out_true_oe && !clk_out_true_o && clk_out_comp_o)
        else $error("split disabled state not held");
    a_dis_debug: assert property (
        drv_off && st_reg.odrv[3:2] == 2'b11 |=>
        clk_out_true_o == $past(clk_src) && clk_out_true_oe)
        else $error("debug state not toggling");
    a_bias_rsvd: assert property (
        rd_bias |=> hrdata[31:9] == 23'h00_0000)
        else $error("reserved status bits not zero");

endmodule

`default_nettype wire

// ===== test/sbxo_regs_tb.sv
/*
 * Self-checking bench for the bias, crystal and output control bank.
 * Assumes the bank is the only AHB-Lite slave, so hready is hreadyout.
 */
`timescale 1ns/10ps
`default_nettype none

module sbxo_regs_tb
    import sbxo_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic cal_done = 1'b0;
    logic cal_fail = 1'b0;
    logic [2:0] cal_code = 3'h0;
    logic [2:0] cal_eff = 3'h0;
    logic cal_cmp = 1'b0;
    logic clk_src = 1'b0;
    logic ext_dis = 1'b0;
    logic lvds = 1'b0;
    logic hreadyout, irq, osc_on, div_on, t_o, t_oe, c_o, c_oe;
    logic [31:0] hrdata;
    logic [1:0] gain;
    logic [13:0] ratio;
    logic hresp;
    logic [5:0] cxo, cxi;
    logic [31:0] sts_e = 32'h0000_0000;
    logic [31:0] obs;
    logic rd_dp = 1'b0;
    logic obs_req = 1'b0;
    logic [31:0] notes[$];
    logic [31:0] xo_sh = 32'h0001_5F1F;
    logic [31:0] od_sh = 32'h0000_8069;
    logic [3:0] odrv_sh = 4'h0;
    logic [31:0] seed = 32'h0000_005C;
    logic [31:0] last;
    int fails = 0;
    int comparisons = 0;

    // A pin that is not driven reads as 0 here, so a floating level hides.
    assign obs = {9'h000, ratio, gain, osc_on, div_on, irq,
                  t_o & t_oe, t_oe, c_o & c_oe, c_oe};

    sbxo_regs uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .cal_done_in(cal_done),
        .cal_fail_in(cal_fail), .cal_code_in(cal_code),
        .cal_eff_in(cal_eff), .cal_cmp_in(cal_cmp), .clk_src(clk_src),
        .ext_disable(ext_dis), .lvds_mode(lvds),
        .osc_regulator_on(osc_on), .gain_boost(gain), .cap_xout(cxo),
        .cap_xin(cxi), .divider_regulator_on(div_on), .div_ratio(ratio),
        .clk_out_true_o(t_o), .clk_out_true_oe(t_oe),
        .clk_out_comp_o(c_o), .clk_out_comp_oe(c_oe), .irq(irq)
    );

    always #20 hclk = ~hclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // legal load codes
    // Software must never write a reserved load code, so random codes in
    // the reserved top range are folded back into the legal range.
    function automatic logic [5:0] cap_ok(input logic [5:0] c);
        return (c > SBXO_CAP_MAX) ? c - 6'h10 : c;
    endfunction

    function logic [3:0] pins_e(input logic cs);
        if (odrv_sh[0])
            return 4'h0;
        if (!(odrv_sh[1] | ext_dis))
            return {cs, 1'b1, ~cs, 1'b1};
        case (odrv_sh[3:2])
            2'd0: return {2'b01, lvds, 1'b1};
            2'd1: return 4'h7;
            2'd2: return 4'h0;
            default: return {cs, 1'b1, ~cs, 1'b1};
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] e);
        comparisons++;
        if (seen !== e)
        begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, e);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Entered just after a rising edge; returns at the data-phase edge.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        if (a == SBXO_ADDR_XO)
            xo_sh = d & 32'h0007_FFFF;
        if (a == SBXO_ADDR_OD)
            od_sh = d & 32'h0000_BFFF;
        if (a == SBXO_ADDR_ODRV)
            odrv_sh = d[3:0];
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        notes.push_back(e);
        notes.push_back(32'h0000_0000);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // The pins are registered, so the clock level is set one edge early.
    task automatic look(input logic cs, input logic ie);
        clk_src <= cs;
        @(posedge hclk);
        notes.push_back({9'h000, od_sh[13:0], xo_sh[15:14], xo_sh[16],
                         od_sh[15], ie, pins_e(cs)});
        notes.push_back({20'h0_0000, xo_sh[13:8], xo_sh[5:0]});
        obs_req <= 1'b1;
        @(posedge hclk);
        obs_req <= 1'b0;
    endtask

    always @(posedge hclk)
        rd_dp <= hsel & htrans[1] & ~hwrite & hreadyout;

    // Sampling at the falling edge sees the data phase fully settled.
    always @(negedge hclk)
    begin
        if (rd_dp)
        begin
            check(hrdata, notes.pop_front());
            check({31'h0000_0000, hresp}, notes.pop_front());
        end
        if (obs_req)
        begin
            check(obs, notes.pop_front());
            check({20'h0_0000, cxo, cxi}, notes.pop_front());
        end
    end

    initial
    begin
        #400000;
        fails++;
        conclude();
    end

    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(SBXO_ADDR_XO, 32'h0001_5F1F);
        rd(SBXO_ADDR_OD, 32'h0000_8069);
        rd(SBXO_ADDR_ODRV, 32'h0000_0000);
        look(1'b1, 1'b0);
        cal_fail <= 1'b1;
        cal_code <= 3'h5;
        cal_eff <= 3'h3;
        cal_cmp <= 1'b1;
        @(posedge hclk);
        rd(SBXO_ADDR_BIAS, 32'h0000_0100);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            last = {23'h00_0000, seed[7:0], 1'b1};
            if (i == 0)
                sts_e = {30'h0000_0000, seed[0], 1'b1};
            cal_done <= 1'b1;
            cal_fail <= seed[0];
            cal_code <= seed[3:1];
            cal_eff <= seed[6:4];
            cal_cmp <= seed[7];
            @(posedge hclk);
            rd(SBXO_ADDR_BIAS, last);
        end
        wr(SBXO_ADDR_BIAS, 32'hFFFF_FFFF);
        rd(SBXO_ADDR_BIAS, last);
        rd(SBXO_ADDR_IRQ_STS, sts_e);
        for (int g = 0; g < 4; g++)
        begin
            seed = lfsr(seed);
            wr(SBXO_ADDR_XO, {seed[31:16], g[1:0], cap_ok(seed[13:8]),
                              seed[7:6], cap_ok(seed[5:0])});
            rd(SBXO_ADDR_XO, xo_sh);
            look(1'b0, 1'b0);
        end
        wr(SBXO_ADDR_OD, 32'hFFFF_FFFF);
        rd(SBXO_ADDR_OD, 32'h0000_BFFF);
        wr(SBXO_ADDR_OD, 32'h0000_000A);
        rd(SBXO_ADDR_OD, 32'h0000_000A);
        look(1'b1, 1'b0);
        for (int k = 0; k < 8; k++)
        begin
            lvds <= k[0];
            wr(SBXO_ADDR_ODRV, {28'h000_0000, k[2:1], 2'b10});
            look(1'b0, 1'b0);
            look(1'b1, 1'b0);
        end
        wr(SBXO_ADDR_ODRV, 32'h0000_0004);
        ext_dis <= 1'b1;
        look(1'b1, 1'b0);
        wr(SBXO_ADDR_ODRV, 32'hFFFF_FFFD);
        rd(SBXO_ADDR_ODRV, 32'h0000_000D);
        look(1'b1, 1'b0);
        ext_dis <= 1'b0;
        wr(SBXO_ADDR_ODRV, 32'h0000_0000);
        look(1'b1, 1'b0);
        wr(SBXO_ADDR_IRQ_CLR, 32'h0000_000F);
        rd(SBXO_ADDR_IRQ_STS, 32'h0000_0000);
        wr(SBXO_ADDR_XO, 32'h0000_0030);
        rd(SBXO_ADDR_IRQ_STS, 32'h0000_0004);
        look(1'b0, 1'b0);
        wr(SBXO_ADDR_IRQ_EN, 32'h0000_0004);
        look(1'b0, 1'b1);
        wr(SBXO_ADDR_OD, 32'h0000_8009);
        rd(SBXO_ADDR_IRQ_STS, 32'h0000_000C);
        wr(SBXO_ADDR_IRQ_CLR, 32'h0000_0004);
        look(1'b0, 1'b0);
        rd(SBXO_ADDR_IRQ_STS, 32'h0000_0008);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        @(posedge hclk);
        conclude();
    end
endmodule

`default_nettype wire
